// file: design/acdsr_defines.svh
`ifndef ACDSR_DEFINES_SVH
`define ACDSR_DEFINES_SVH

// register addresses
`define ACDSR_A_STATUS 6'h00
`define ACDSR_A_CTRL 6'h01
`define ACDSR_A_FLAGS 6'h06
`define ACDSR_A_ENABLES 6'h07
`define ACDSR_A_TALLY 6'h08
`define ACDSR_A_CHAN 6'h09
`define ACDSR_A_CFG 6'h19
`define ACDSR_A_FLT 6'h21
`define ACDSR_A_OFS 6'h29
`define ACDSR_A_GAIN 6'h31
`define ACDSR_A_END 6'h39
`define ACDSR_N_CHAN 6'h10
`define ACDSR_N_SETUP 6'h08

// conversion control fields
`define ACDSR_CTL_MASK 16'h1FFF
`define ACDSR_CTL_CLK 1:0
`define ACDSR_CTL_MODE 5:2
`define ACDSR_CTL_PWR 7:6
`define ACDSR_CTL_REFEN 8
`define ACDSR_CTL_CSEN 9
`define ACDSR_CTL_APPEND 10
`define ACDSR_CTL_CONTRD 11
`define ACDSR_CTL_RDYDEL 12
`define ACDSR_CTL_RST 16'h0000

// power levels
`define ACDSR_PWR_LOW 2'h0
`define ACDSR_PWR_MID 2'h1
`define ACDSR_PWR_FULL 2'h2

// operating modes
`define ACDSR_MODE_CONT 4'h0
`define ACDSR_MODE_SINGLE 4'h1
`define ACDSR_MODE_STANDBY 4'h2
`define ACDSR_MODE_PDOWN 4'h3
`define ACDSR_MODE_IDLE 4'h4
`define ACDSR_MODE_INT_ZERO 4'h5
`define ACDSR_MODE_INT_FULL 4'h6
`define ACDSR_MODE_SYS_ZERO 4'h7
`define ACDSR_MODE_SYS_FULL 4'h8

// diagnostics
`define ACDSR_EN_MASK 24'h7FFFFF
`define ACDSR_EN_RST 24'h000040
`define ACDSR_EN_TALLY 22
`define ACDSR_EN_LDOCHK 20:19
`define ACDSR_EN_DIRECT 18:0
`define ACDSR_FLAG_MASK 24'h0FFAFF
`define ACDSR_FLAG_RST 24'h000000
`define ACDSR_ST_ERR 6

// channel entry fields and register resets
`define ACDSR_CH_EN 15
`define ACDSR_CH_SETUP 14:12
`define ACDSR_CH_POS 9:5
`define ACDSR_CH_NEG 4:0
`define ACDSR_CH0_RST 16'h8001
`define ACDSR_CHN_RST 16'h0001
`define ACDSR_CFG_RST 16'h0860
`define ACDSR_FLT_RST 24'h060180
`define ACDSR_OFS_RST 24'h800000
`define ACDSR_TALLY_RST 8'h00

`endif

// file: design/acdsr_pkg.sv
package acdsr_pkg;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [23:0] flags;
    logic [23:0] en;
    logic [15:0][15:0] chan;
    logic [7:0][15:0] cfg;
    logic [7:0][23:0] flt;
    logic [7:0][23:0] ofs;
    logic [7:0][23:0] gain;
    logic [23:0] rdata;
    logic rvalid;
    logic [1:0] pwr;
    logic err;
    logic [3:0] cidx;
    logic cval;
    logic [4:0] pos;
    logic [4:0] neg;
    logic [2:0] sidx;
    logic [15:0] scfg;
    logic [23:0] sflt;
    logic [23:0] sgain;
    logic [23:0] sofs;
  } acdsr_regs_t;

  typedef struct packed {
    logic [3:0] idx;
    logic any;
  } acdsr_seq_t;

  typedef struct packed {
    logic [7:0] count;
  } acdsr_tally_t;

endpackage

// file: design/acdsr_tally.sv
`timescale 1ns/100ps
`include "acdsr_defines.svh"

module acdsr_tally import acdsr_pkg::*; (
  input wire logic clk_in, // master clock
  input wire logic nrst_in, // sync reset, active low
  input wire logic ce_in, // clock enable
  input wire logic on_in, // tally enable
  output logic [7:0] count_out // master clock pulse tally
);

  acdsr_tally_t s_r;
  acdsr_tally_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    // free-running wrap: software samples twice and takes the difference
    if (on_in) begin
      s_nxt.count = s_r.count + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s_r.count <= `ACDSR_TALLY_RST;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign count_out = s_r.count;

endmodule // acdsr_tally

// file: design/acdsr_seq.sv
`timescale 1ns/100ps
`include "acdsr_defines.svh"

module acdsr_seq import acdsr_pkg::*; (
  input wire logic clk_in, // clock
  input wire logic nrst_in, // sync reset, active low
  input wire logic ce_in, // clock enable
  input wire logic [15:0] en_in, // channel entry enables
  input wire logic step_in, // conversion finished, move on
  output logic [3:0] idx_out, // current channel entry
  output logic any_out // at least one entry enabled
);

  acdsr_seq_t s_r;
  acdsr_seq_t s_nxt;

  // next enabled entry after from, wrapping; returns from itself if alone
  function automatic logic [3:0] next_en(input logic [15:0] en, input logic [3:0] from);
    logic [3:0] res;
    logic found;
    logic [3:0] k;
    res = from;
    found = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      k = from + i[3:0];
      if (!found && en[k]) begin
        res = k;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.any = |en_in;
    if (!en_in[s_r.idx]) begin
      s_nxt.idx = next_en(en_in, 4'hF);
    end else if (step_in) begin
      s_nxt.idx = next_en(en_in, s_r.idx);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s_r.idx <= 4'h0;
      s_r.any <= 1'b0;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign idx_out = s_r.idx;
  assign any_out = s_r.any;

endmodule // acdsr_seq

// file: design/acdsr_regs.sv
`timescale 1ns/100ps
`include "acdsr_defines.svh"

module acdsr_regs import acdsr_pkg::*; #(
  parameter logic [23:0] GAIN_RST = 24'h500000 // arbitrary factory-trim stand-in
) (
  input wire logic clk_in, // master clock
  input wire logic nrst_in, // sync reset, active low
  input wire logic ce_in, // clock enable, freezes all state when low
  input wire logic [5:0] addr_in, // register address
  input wire logic [23:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  input wire logic [23:0] diag_event_in, // raw diagnostic events
  input wire logic conv_done_in, // conversion finished pulse
  input wire logic cal_done_in, // calibration finished pulse
  input wire logic [23:0] cal_coef_in, // calibration result
  output logic [23:0] rdata_out, // read data
  output logic rvalid_out, // read data valid pulse
  output logic [1:0] power_level_out, // active power level
  output logic [3:0] op_mode_out, // operating mode
  output logic [1:0] clk_sel_out, // clock source select
  output logic ref_en_out, // internal reference enable
  output logic cs_gate_out, // chip-select gated readback
  output logic append_status_out, // append status to data
  output logic continuous_readback_out, // continuous readback
  output logic ready_output_delay_out, // ready output delay
  output logic err_out, // summary error
  output logic [3:0] chan_idx_out, // active channel entry
  output logic chan_valid_out, // an entry is enabled and routed
  output logic [4:0] positive_input_select_out, // routed positive pin
  output logic [4:0] negative_input_select_out, // routed negative pin
  output logic [2:0] setup_idx_out, // setup of active entry
  output logic [15:0] setup_config_out, // its configuration
  output logic [23:0] setup_filter_out, // its filter
  output logic [23:0] setup_gain_out, // its gain coefficient
  output logic [23:0] setup_offset_out // its offset coefficient
);

  acdsr_regs_t s_r;
  acdsr_regs_t s_nxt;

  logic [3:0] cur_idx;
  logic cur_any;
  logic [7:0] tally;
  logic [15:0] chan_en;
  logic [23:0] flag_en;
  logic [3:0] mode;
  logic run;
  logic [2:0] cur_setup;
  logic [5:0] r_ch;
  logic [5:0] r_cf;
  logic [5:0] r_fl;
  logic [5:0] r_of;
  logic [5:0] r_gn;

  function automatic logic [5:0] rel(input logic [5:0] a, input logic [5:0] base);
    return a - base;
  endfunction

  function automatic logic [1:0] clamp_pwr(input logic [1:0] p);
    // the unused fourth code runs at full power rather than an undefined level
    return (p == `ACDSR_PWR_LOW || p == `ACDSR_PWR_MID) ? p : `ACDSR_PWR_FULL;
  endfunction

  assign r_ch = rel(addr_in, `ACDSR_A_CHAN);
  assign r_cf = rel(addr_in, `ACDSR_A_CFG);
  assign r_fl = rel(addr_in, `ACDSR_A_FLT);
  assign r_of = rel(addr_in, `ACDSR_A_OFS);
  assign r_gn = rel(addr_in, `ACDSR_A_GAIN);

  assign mode = s_r.ctrl[`ACDSR_CTL_MODE];
  assign run = (mode == `ACDSR_MODE_CONT) || (mode == `ACDSR_MODE_SINGLE);
  assign cur_setup = s_r.chan[cur_idx][`ACDSR_CH_SETUP];

  always_comb begin
    chan_en = '0;
    for (int i = 0; i < 16; i++) begin
      chan_en[i] = s_r.chan[i][`ACDSR_CH_EN];
    end
  end

  // flag enables line up with enable bits except the two-bit capacitor check field
  always_comb begin
    flag_en = '0;
    flag_en[`ACDSR_EN_DIRECT] = s_r.en[`ACDSR_EN_DIRECT];
    flag_en[19] = |s_r.en[`ACDSR_EN_LDOCHK];
    flag_en = flag_en & `ACDSR_FLAG_MASK;
  end

  acdsr_seq u_seq (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .en_in(chan_en),
    .step_in(conv_done_in && run),
    .idx_out(cur_idx),
    .any_out(cur_any)
  );

  acdsr_tally u_tally (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .on_in(s_r.en[`ACDSR_EN_TALLY]),
    .count_out(tally)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;

    // software writes; read-only and unmapped addresses ignore them
    if (wr_in) begin
      if (addr_in == `ACDSR_A_CTRL) begin
        s_nxt.ctrl = wdata_in[15:0] & `ACDSR_CTL_MASK;
      end else if (addr_in == `ACDSR_A_ENABLES) begin
        s_nxt.en = wdata_in & `ACDSR_EN_MASK;
      end else if (addr_in >= `ACDSR_A_CHAN && addr_in < `ACDSR_A_CFG) begin
        s_nxt.chan[r_ch[3:0]] = wdata_in[15:0];
      end else if (addr_in >= `ACDSR_A_CFG && addr_in < `ACDSR_A_FLT) begin
        s_nxt.cfg[r_cf[2:0]] = wdata_in[15:0];
      end else if (addr_in >= `ACDSR_A_FLT && addr_in < `ACDSR_A_OFS) begin
        s_nxt.flt[r_fl[2:0]] = wdata_in;
      end else if (addr_in >= `ACDSR_A_OFS && addr_in < `ACDSR_A_GAIN) begin
        s_nxt.ofs[r_of[2:0]] = wdata_in;
      end else if (addr_in >= `ACDSR_A_GAIN && addr_in < `ACDSR_A_END) begin
        s_nxt.gain[r_gn[2:0]] = wdata_in;
      end
    end

    // calibration result lands after the write so it wins a same-cycle clash
    if (cal_done_in) begin
      if (mode == `ACDSR_MODE_INT_ZERO || mode == `ACDSR_MODE_SYS_ZERO) begin
        s_nxt.ofs[cur_setup] = cal_coef_in;
      end else if (mode == `ACDSR_MODE_INT_FULL || mode == `ACDSR_MODE_SYS_FULL) begin
        s_nxt.gain[cur_setup] = cal_coef_in;
      end
    end

    // reads return the value before this cycle's updates
    if (rd_in) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = '0;
      if (addr_in == `ACDSR_A_STATUS) begin
        s_nxt.rdata[3:0] = cur_idx;
        s_nxt.rdata[`ACDSR_ST_ERR] = s_r.err;
      end else if (addr_in == `ACDSR_A_CTRL) begin
        s_nxt.rdata[15:0] = s_r.ctrl;
      end else if (addr_in == `ACDSR_A_FLAGS) begin
        s_nxt.rdata = s_r.flags;
        s_nxt.flags = `ACDSR_FLAG_RST;
      end else if (addr_in == `ACDSR_A_ENABLES) begin
        s_nxt.rdata = s_r.en;
      end else if (addr_in == `ACDSR_A_TALLY) begin
        s_nxt.rdata[7:0] = tally;
      end else if (addr_in >= `ACDSR_A_CHAN && addr_in < `ACDSR_A_CFG) begin
        s_nxt.rdata[15:0] = s_r.chan[r_ch[3:0]];
      end else if (addr_in >= `ACDSR_A_CFG && addr_in < `ACDSR_A_FLT) begin
        s_nxt.rdata[15:0] = s_r.cfg[r_cf[2:0]];
      end else if (addr_in >= `ACDSR_A_FLT && addr_in < `ACDSR_A_OFS) begin
        s_nxt.rdata = s_r.flt[r_fl[2:0]];
      end else if (addr_in >= `ACDSR_A_OFS && addr_in < `ACDSR_A_GAIN) begin
        s_nxt.rdata = s_r.ofs[r_of[2:0]];
      end else if (addr_in >= `ACDSR_A_GAIN && addr_in < `ACDSR_A_END) begin
        s_nxt.rdata = s_r.gain[r_gn[2:0]];
      end
    end

    // an event in the clear cycle still sets its flag
    s_nxt.flags = s_nxt.flags | (diag_event_in & flag_en);
    s_nxt.err = |(s_nxt.flags & flag_en);

    s_nxt.pwr = clamp_pwr(s_r.ctrl[`ACDSR_CTL_PWR]);

    // routed selection trails the sequencer by one cycle so outputs stay registered
    s_nxt.cidx = cur_idx;
    s_nxt.cval = cur_any && chan_en[cur_idx];
    s_nxt.pos = s_r.chan[cur_idx][`ACDSR_CH_POS];
    s_nxt.neg = s_r.chan[cur_idx][`ACDSR_CH_NEG];
    s_nxt.sidx = cur_setup;
    s_nxt.scfg = s_r.cfg[cur_setup];
    s_nxt.sflt = s_r.flt[cur_setup];
    s_nxt.sgain = s_r.gain[cur_setup];
    s_nxt.sofs = s_r.ofs[cur_setup];
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s_r.ctrl <= `ACDSR_CTL_RST;
      s_r.flags <= `ACDSR_FLAG_RST;
      s_r.en <= `ACDSR_EN_RST;
      for (int i = 0; i < 16; i++) begin
        s_r.chan[i] <= (i == 0) ? `ACDSR_CH0_RST : `ACDSR_CHN_RST;
      end
      for (int i = 0; i < 8; i++) begin
        s_r.cfg[i] <= `ACDSR_CFG_RST;
        s_r.flt[i] <= `ACDSR_FLT_RST;
        s_r.ofs[i] <= `ACDSR_OFS_RST;
        s_r.gain[i] <= GAIN_RST;
      end
      s_r.rdata <= '0;
      s_r.rvalid <= 1'b0;
      s_r.pwr <= `ACDSR_PWR_LOW;
      s_r.err <= 1'b0;
      s_r.cidx <= 4'h0;
      s_r.cval <= 1'b0;
      s_r.pos <= 5'h00;
      s_r.neg <= 5'h00;
      s_r.sidx <= 3'h0;
      s_r.scfg <= `ACDSR_CFG_RST;
      s_r.sflt <= `ACDSR_FLT_RST;
      s_r.sgain <= GAIN_RST;
      s_r.sofs <= `ACDSR_OFS_RST;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign rdata_out = s_r.rdata;
  assign rvalid_out = s_r.rvalid;
  assign power_level_out = s_r.pwr;
  assign op_mode_out = s_r.ctrl[`ACDSR_CTL_MODE];
  assign clk_sel_out = s_r.ctrl[`ACDSR_CTL_CLK];
  assign ref_en_out = s_r.ctrl[`ACDSR_CTL_REFEN];
  assign cs_gate_out = s_r.ctrl[`ACDSR_CTL_CSEN];
  assign append_status_out = s_r.ctrl[`ACDSR_CTL_APPEND];
  assign continuous_readback_out = s_r.ctrl[`ACDSR_CTL_CONTRD];
  assign ready_output_delay_out = s_r.ctrl[`ACDSR_CTL_RDYDEL];
  assign err_out = s_r.err;
  assign chan_idx_out = s_r.cidx;
  assign chan_valid_out = s_r.cval;
  assign positive_input_select_out = s_r.pos;
  assign negative_input_select_out = s_r.neg;
  assign setup_idx_out = s_r.sidx;
  assign setup_config_out = s_r.scfg;
  assign setup_filter_out = s_r.sflt;
  assign setup_gain_out = s_r.sgain;
  assign setup_offset_out = s_r.sofs;

endmodule // acdsr_regs

// file: verif/acdsr_regs_asserts.sv
`timescale 1ns/100ps
module acdsr_regs_asserts (
  input wire logic clk_in, // clock
  input wire logic nrst_in, // reset
  input wire logic ce_in, // enable
  input wire logic [5:0] addr_in, // address
  input wire logic [23:0] wdata_in, // data
  input wire logic wr_in, // write
  input wire logic rd_in, // read
  input wire logic [23:0] diag_event_in, // events
  input wire logic conv_done_in, // conversion
  input wire logic cal_done_in, // calibration
  input wire logic [23:0] cal_coef_in, // coefficient
  input wire logic rvalid_out, // valid
  input wire logic [23:0] rdata_out, // read data
  input wire logic [1:0] power_level_out, // power
  input wire logic [3:0] op_mode_out, // mode
  input wire logic ref_en_out, // reference
  input wire logic append_status_out, // append
  input wire logic continuous_readback_out, // readback
  input wire logic err_out, // error
  input wire logic [3:0] chan_idx_out, // entry
  input wire logic [23:0] setup_gain_out, // gain
  input wire logic [23:0] setup_offset_out // offset
);
  default clocking dcb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  logic go;
  logic ctl_wr;
  logic [15:0] ctl_r;
  logic [1:0] pwr_exp;
  logic [3:0] hist_r;
  assign go = nrst_in && ce_in;
  assign ctl_wr = go && wr_in && addr_in == 6'h01;
  // code 3 runs as full power
  assign pwr_exp = (ctl_r[7:6] == 2'h3) ? 2'h2 : ctl_r[7:6];
  always_ff @(posedge clk_in) begin
    if (ctl_wr) begin
      ctl_r <= wdata_in[15:0];
    end
    // the entry may only move shortly after a step or a register write
    hist_r <= nrst_in ? {hist_r[2:0], go && (conv_done_in || wr_in)} : 4'h0;
  end
  a_power_level: assert property (ctl_wr |-> ##2 power_level_out == pwr_exp)
    else $error("power level differs from control");
  a_mode_follow: assert property (ctl_wr |-> ##2 op_mode_out == ctl_r[5:2])
    else $error("mode differs from control");
  a_ref_enable: assert property (ctl_wr |-> ##2 ref_en_out == ctl_r[8])
    else $error("reference enable differs");
  a_readback_bits: assert property (ctl_wr |-> ##2
    {continuous_readback_out, append_status_out} == ctl_r[11:10])
    else $error("readback bits differ");
  a_err_cause: assert property ($rose(err_out) |->
    |$past(diag_event_in) || |$past(diag_event_in, 2))
    else $error("error rose without event");
  a_offset_cal: assert property (go && cal_done_in && op_mode_out == 4'h5
    |-> ##[1:3] setup_offset_out == cal_coef_in)
    else $error("offset not calibrated");
  a_gain_cal: assert property (go && cal_done_in && op_mode_out == 4'h6
    |-> ##[1:3] setup_gain_out == cal_coef_in)
    else $error("gain not calibrated");
  a_seq_moves: assert property ($changed(chan_idx_out) |-> |hist_r)
    else $error("entry moved without cause");
  a_freeze_hold: assert property (!ce_in |=> $stable(chan_idx_out)
    && $stable(rvalid_out) && $stable(rdata_out))
    else $error("state moved with enable low");
  a_reset_state: assert property ($rose(nrst_in) |->
    setup_offset_out == 24'h800000 && op_mode_out == 4'h0 && !err_out)
    else $error("wrong state after reset");
endmodule // acdsr_regs_asserts

// file: verif/acdsr_host.sv
`timescale 1ns/100ps
module acdsr_host (
  input wire logic clk_in, // clock
  input wire logic [23:0] rdata_in, // read data
  input wire logic rvalid_in, // read valid
  output logic [5:0] addr_out, // address
  output logic [23:0] wdata_out, // write data
  output logic wr_out, // write strobe
  output logic rd_out // read strobe
);
  initial begin
    addr_out = 6'h00;
    wdata_out = 24'h000000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one word per strobe; released lines show junk, not the old value
  task automatic put(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic get(input logic [5:0] a, output logic [23:0] d, output logic v);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
    v = rvalid_in;
  endtask
endmodule // acdsr_host

// file: verif/tb_acdsr_regs.sv
`timescale 1ns/100ps
module tb_acdsr_regs;
  localparam logic [23:0] GAIN_R = 24'h5A5A5A;
  logic clk_in;
  logic nrst_in;
  logic ce_in;
  logic [5:0] addr_in;
  logic [23:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [23:0] diag_event_in;
  logic conv_done_in;
  logic cal_done_in;
  logic [23:0] cal_coef_in;
  logic [23:0] rdata_out;
  logic rvalid_out;
  logic [1:0] power_level_out;
  logic [3:0] op_mode_out;
  logic [1:0] clk_sel_out;
  logic cs_gate_out;
  logic ready_output_delay_out;
  logic chan_valid_out;
  logic [23:0] setup_filter_out;
  logic ref_en_out;
  logic append_status_out;
  logic continuous_readback_out;
  logic err_out;
  logic [3:0] chan_idx_out;
  logic [4:0] positive_input_select_out;
  logic [4:0] negative_input_select_out;
  logic [2:0] setup_idx_out;
  logic [15:0] setup_config_out;
  logic [23:0] setup_gain_out;
  logic [23:0] setup_offset_out;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  acdsr_regs #(.GAIN_RST(GAIN_R)) acdsr_regs_inst (.clk_in, .nrst_in, .ce_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .diag_event_in, .conv_done_in, .cal_done_in, .cal_coef_in,
    .rdata_out, .rvalid_out, .power_level_out, .op_mode_out, .clk_sel_out, .ref_en_out,
    .cs_gate_out, .append_status_out, .continuous_readback_out, .ready_output_delay_out,
    .err_out, .chan_idx_out, .chan_valid_out, .positive_input_select_out,
    .negative_input_select_out, .setup_idx_out, .setup_config_out, .setup_filter_out,
    .setup_gain_out, .setup_offset_out);
  acdsr_host host_inst (.clk_in, .rdata_in(rdata_out), .rvalid_in(rvalid_out),
    .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] d;
    logic v;
    host_inst.get(a, d, v);
    chk(24'(v), 24'h1, "valid");
    chk(d, exp, "readback");
  endtask
  task automatic conclude();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_in);
    s = 1'b1;
    @(negedge clk_in);
    s = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  // one-cycle diagnostic event word
  task automatic ev(input logic [23:0] d);
    @(negedge clk_in);
    diag_event_in = d;
    @(negedge clk_in);
    diag_event_in = 24'h000000;
  endtask
  task automatic t_reset();
    chk_reg(6'h01, 24'h000000);
    chk_reg(6'h06, 24'h000000);
    chk_reg(6'h07, 24'h000040);
    chk_reg(6'h08, 24'h000000);
    chk_reg(6'h09, 24'h008001);
    chk_reg(6'h0A, 24'h000001);
    chk_reg(6'h19, 24'h000860);
    chk_reg(6'h21, 24'h060180);
    chk_reg(6'h29, 24'h800000);
    chk_reg(6'h31, GAIN_R);
    chk_reg(6'h03, 24'h000000);
  endtask
  task automatic t_control();
    logic [15:0] c;
    for (int m = 0; m < 9; m++) begin
      c = 16'((m % 3) << 6 | m << 2 | (m & 1) << 8 | (m & 6) << 9 | (m & 3));
      host_inst.put(6'h01, {8'h00, c});
      repeat (2) @(negedge clk_in);
      chk(24'(power_level_out), 24'(m % 3), "power");
      chk(24'(op_mode_out), 24'(m), "mode");
      chk(24'(ref_en_out), 24'(c[8]), "ref");
      chk(24'(clk_sel_out), 24'(m & 3), "clock");
      chk(24'({continuous_readback_out, append_status_out}), 24'(c[11:10]), "rd");
      chk_reg(6'h01, {8'h00, c});
    end
    host_inst.put(6'h01, 24'hFFFFFF);
    repeat (2) @(negedge clk_in);
    chk(24'(power_level_out), 24'h2, "power");
    chk(24'({cs_gate_out, ready_output_delay_out}), 24'h3, "iface");
    chk_reg(6'h01, 24'h001FFF);
    host_inst.put(6'h01, 24'h000000);
    repeat (2) @(negedge clk_in);
    chk(24'({cs_gate_out, ready_output_delay_out}), 24'h0, "iface");
  endtask
  task automatic t_diag();
    // only the write-blocking check reports until enables change
    ev(24'h0FFAFF);
    chk(24'(err_out), 24'h1, "err");
    chk_reg(6'h00, 24'h000040);
    chk_reg(6'h06, 24'h000040);
    chk(24'(err_out), 24'h0, "err");
    // a level event spanning the clearing read sets its flag again
    @(negedge clk_in);
    diag_event_in = 24'h000040;
    chk_reg(6'h06, 24'h000040);
    diag_event_in = 24'h000000;
    chk_reg(6'h06, 24'h000040);
    chk_reg(6'h06, 24'h000000);
    host_inst.put(6'h07, 24'hFFFFFF);
    chk_reg(6'h07, 24'h7FFFFF);
    ev(24'hFFFFFF);
    chk_reg(6'h06, 24'h0FFAFF);
    host_inst.put(6'h07, 24'h100000);
    ev(24'h080000);
    chk_reg(6'h06, 24'h080000);
    host_inst.put(6'h07, 24'h000000);
    ev(24'h000040);
    chk_reg(6'h06, 24'h000000);
  endtask
  task automatic t_tally();
    logic [23:0] a;
    logic [23:0] b;
    logic v;
    host_inst.put(6'h07, 24'h400040);
    host_inst.get(6'h08, a, v);
    @(negedge clk_in);
    ce_in = 1'b0;
    repeat (5) @(negedge clk_in);
    ce_in = 1'b1;
    host_inst.get(6'h08, b, v);
    chk(b, 24'(8'(a[7:0] + 8'h03)), "tally");
    host_inst.put(6'h07, 24'h000040);
    host_inst.get(6'h08, a, v);
    host_inst.put(6'h08, 24'h0000FF);
    chk_reg(6'h08, a);
  endtask
  task automatic t_seq();
    logic [16:0] ex [3] = '{{4'h2, 5'd7, 5'd8, 3'd3}, {4'h5, 5'd17, 5'd18, 3'd7},
      {4'h0, 5'd0, 5'd1, 3'd0}};
    logic [15:0] cf [3] = '{16'h1234, 16'h0ABC, 16'h0860};
    pulse(conv_done_in);
    chk(24'(chan_idx_out), 24'h0, "single");
    chk(24'(chan_valid_out), 24'h1, "valid");
    host_inst.put(6'h1C, 24'h001234);
    host_inst.put(6'h20, 24'h000ABC);
    host_inst.put(6'h0B, 24'h00B0E8);
    host_inst.put(6'h0E, 24'h00F232);
    repeat (4) @(negedge clk_in);
    for (int i = 0; i < 6; i++) begin
      pulse(conv_done_in);
      chk(24'({chan_idx_out, positive_input_select_out, negative_input_select_out,
        setup_idx_out}), 24'(ex[i % 3]), "entry");
      chk(24'(setup_config_out), 24'(cf[i % 3]), "setup");
    end
    host_inst.put(6'h09, 24'h000001);
    host_inst.put(6'h0B, 24'h0030E8);
    repeat (2) begin
      pulse(conv_done_in);
      chk(24'(chan_idx_out), 24'h5, "single");
    end
    chk_reg(6'h00, 24'h000005);
  endtask
  task automatic t_cal();
    host_inst.put(6'h01, 24'h000014);
    cal_coef_in = 24'h123456;
    pulse(cal_done_in);
    chk(setup_offset_out, 24'h123456, "offset");
    chk_reg(6'h30, 24'h123456);
    host_inst.put(6'h01, 24'h000018);
    cal_coef_in = 24'h654321;
    pulse(cal_done_in);
    chk(setup_gain_out, 24'h654321, "gain");
    chk_reg(6'h29, 24'h800000);
    host_inst.put(6'h38, 24'h0F0F0F);
    chk_reg(6'h38, 24'h0F0F0F);
    host_inst.put(6'h28, 24'h0A0B0C);
    repeat (2) @(negedge clk_in);
    chk(setup_filter_out, 24'h0A0B0C, "filter");
    host_inst.put(6'h0E, 24'h000001);
    repeat (3) @(negedge clk_in);
    chk(24'(chan_valid_out), 24'h0, "valid");
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end
  initial begin
    nrst_in = 1'b0;
    ce_in = 1'b1;
    diag_event_in = 24'h000000;
    conv_done_in = 1'b0;
    cal_done_in = 1'b0;
    cal_coef_in = 24'h000000;
    repeat (3) @(negedge clk_in);
    nrst_in = 1'b1;
    t_reset();
    t_control();
    t_diag();
    t_tally();
    t_seq();
    t_cal();
    conclude();
  end
endmodule // tb_acdsr_regs
bind acdsr_regs acdsr_regs_asserts acdsr_regs_asserts_inst (.clk_in, .nrst_in, .ce_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .diag_event_in, .conv_done_in, .cal_done_in,
  .cal_coef_in, .rvalid_out, .rdata_out, .power_level_out, .op_mode_out, .ref_en_out,
  .append_status_out, .continuous_readback_out, .err_out, .chan_idx_out, .setup_gain_out,
  .setup_offset_out);
